// ==== design/pbtw_pkg.sv ====
// Shared constants for the burst transition and wait block
package pbtw_pkg;
    localparam int          PBTW_DATA_W       = 16;
    localparam int          PBTW_FIFO_DEPTH   = 8;
    localparam int          PBTW_LAT_W        = 4;
    localparam logic [3:0]  PBTW_LAT_RST      = 4'h5;
    localparam logic [3:0]  PBTW_LAT_MIN      = 4'h2;
    localparam int          PBTW_CLK_PS       = 5000;
    localparam int          PBTW_BURST_MAX_NS = 2500;
    localparam int          PBTW_BURST_MAX_CYC = (PBTW_BURST_MAX_NS * 1000) / PBTW_CLK_PS;
    localparam int          PBTW_CYC_W        = 10;
    typedef enum logic [1:0] {PBTW_IDLE, PBTW_LATENCY, PBTW_DATA} pbtw_state_t;
endpackage

// ==== design/pbtw_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pbtw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Full and empty come straight from the count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Storage has no reset; only pointers matter
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk) begin
        if (!reset_n || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== design/pbtw_core.sv ====
// Burst framing, latency count and wait pin of the pseudo-static RAM burst port
// Function
// - Wait goes low (data not ready) from the falling edge of chip select or of address-valid; the code takes the address-valid fall only in PBTW_IDLE.
// - Wait goes high (data ready) at the burst clock edge one cycle before the latency count expires.
// - Wait is released to high impedance when chip select returns high.
// - Several rising burst clock edges while address-valid is low are accepted without error.
// - The burst and its latency count start at the first rising edge seen with address-valid low.
`timescale 1ns/100ps
`default_nettype none
module pbtw_core
    import pbtw_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   chip_select_n,
    input  wire logic                   address_valid_n,
    input  wire logic                   burst_clk,
    input  wire logic [PBTW_LAT_W-1:0]  latency,
    input  wire logic [PBTW_DATA_W-1:0] array_data,
    input  wire logic                   array_valid,
    output logic                        array_ready,
    output logic [PBTW_DATA_W-1:0]      dq_out,
    output logic                        dq_strobe,
    output logic                        wait_o,
    output logic                        wait_oe,
    output logic                        burst_active,
    output logic                        burst_overrun
);
    // Burst sequencing state
    pbtw_state_t            state_q;
    pbtw_state_t            state_d;

    // Pin synchronisers and edge history
    logic [1:0]             cs_sync_q;
    logic [1:0]             adv_sync_q;
    logic [1:0]             clk_sync_q;
    logic                   cs_q;
    logic                   adv_q;
    logic                   clk_q;

    // Latency count
    logic [PBTW_LAT_W-1:0]  lat_cnt_q;
    logic [PBTW_LAT_W-1:0]  lat_cnt_d;

    // Wait pin and burst cycle watchdog
    logic                   wait_q;
    logic                   wait_oe_q;
    logic [PBTW_CYC_W-1:0]  cyc_q;
    logic                   overrun_q;

    // Data path towards the pins
    logic [PBTW_DATA_W-1:0] dq_q;
    logic                   strobe_q;
    logic [PBTW_DATA_W-1:0] fifo_data;
    logic                   fifo_valid;

    // Pins cross into mclk through two flops; only stage two is read
    // Reset levels match the idle pins, so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_sync_q  <= 2'h3;
            adv_sync_q <= 2'h3;
            clk_sync_q <= 2'h0;
        end else begin
            cs_sync_q  <= {cs_sync_q[0], chip_select_n};
            adv_sync_q <= {adv_sync_q[0], address_valid_n};
            clk_sync_q <= {clk_sync_q[0], burst_clk};
        end
    end

    // Previous values of the synchronised levels for edge detection
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_q  <= 1'b1;
            adv_q <= 1'b1;
            clk_q <= 1'b0;
        end else begin
            cs_q  <= cs_sync_q[1];
            adv_q <= adv_sync_q[1];
            clk_q <= clk_sync_q[1];
        end
    end

    // Edge decode on synchronised pins
    wire cs_low    = !cs_sync_q[1];
    wire cs_fall   = cs_q && !cs_sync_q[1];
    wire cs_rise   = !cs_q && cs_sync_q[1];
    wire adv_fall  = adv_q && !adv_sync_q[1];
    wire adv_low   = !adv_sync_q[1];
    wire clk_rise  = !clk_q && clk_sync_q[1];

    // Burst control decode
    wire start     = cs_low && adv_low && clk_rise && (state_q == PBTW_IDLE);
    wire lat_last  = (lat_cnt_q == PBTW_LAT_W'(1));
    wire data_beat = (state_q == PBTW_DATA) && clk_rise;
    // Latency below the minimum is clamped so wait still toggles
    wire [PBTW_LAT_W-1:0] lat_clamp = (latency < PBTW_LAT_MIN) ? PBTW_LAT_MIN : latency;

    // Ready edge: the rise that leaves one latency clock to go, which at the
    // minimum latency is the starting rise itself
    wire ready_at_start = start && (lat_clamp == PBTW_LAT_MIN);
    wire ready_in_count = (state_q == PBTW_LATENCY) && clk_rise && (lat_cnt_q == PBTW_LAT_W'(2));
    wire ready_edge     = ready_at_start || ready_in_count;

    // Burst sequencing; later clock edges under address-valid low do not restart
    always_comb begin
        state_d   = state_q;
        lat_cnt_d = lat_cnt_q;
        case (state_q)
            PBTW_IDLE: begin
                if (start) begin
                    state_d   = PBTW_LATENCY;
                    lat_cnt_d = lat_clamp - PBTW_LAT_W'(1);
                end
            end
            PBTW_LATENCY: begin
                if (clk_rise) begin
                    if (lat_last) begin
                        state_d = PBTW_DATA;
                    end
                    lat_cnt_d = lat_cnt_q - PBTW_LAT_W'(1);
                end
            end
            PBTW_DATA: begin
                state_d = PBTW_DATA;
            end
            default: begin
                state_d = PBTW_IDLE;
            end
        endcase
        // Chip select high always closes the burst, the host's way to switch type
        if (!cs_low) begin
            state_d   = PBTW_IDLE;
            lat_cnt_d = '0;
        end
    end

    // State and counter registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q   <= PBTW_IDLE;
            lat_cnt_q <= '0;
        end else begin
            state_q   <= state_d;
            lat_cnt_q <= lat_cnt_d;
        end
    end

    // Wait pin: low on select fall, or on address-valid fall in PBTW_IDLE only, high one clock early, released on deselect
    // Deselect outranks the rest so the pin is never driven once chip select is high
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wait_q    <= 1'b0;
            wait_oe_q <= 1'b0;
        end else if (cs_rise || !cs_low) begin
            wait_q    <= 1'b0;
            wait_oe_q <= 1'b0;
        end else if (cs_fall || (adv_fall && state_q == PBTW_IDLE)) begin
            wait_q    <= 1'b0;
            wait_oe_q <= 1'b1;
        end else if (ready_edge) begin
            wait_q    <= 1'b1;
        end
    end

    // Burst cycle watchdog; the device only flags a host that overstays
    // Limitation: the bound is counted in mclk, so it holds only at the nominal clock
    always_ff @(posedge mclk) begin
        if (!reset_n || !cs_low) begin
            cyc_q     <= '0;
            overrun_q <= 1'b0;
        end else begin
            if (cyc_q != PBTW_CYC_W'(PBTW_BURST_MAX_CYC)) begin
                cyc_q <= cyc_q + PBTW_CYC_W'(1);
            end else begin
                overrun_q <= 1'b1;
            end
        end
    end

    // Array words leave on each data-phase clock; no word means the strobe stays low
    // The strobe marks a fresh word for exactly one clock
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dq_q     <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= data_beat && fifo_valid;
            if (data_beat && fifo_valid) begin
                dq_q <= fifo_data;
            end
        end
    end

    // Prefetch buffer; flushed at burst end so a new burst never sees stale words
    // The array side stalls on array_ready whenever all eight words wait
    pbtw_fifo #(
        .WIDTH (PBTW_DATA_W),
        .DEPTH (PBTW_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .flush     (!cs_low),
        .in_data   (array_data),
        .in_valid  (array_valid && cs_low),
        .in_ready  (array_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (data_beat)
    );

    // Outputs come straight from registers; burst_active is decoded from state_q
    assign dq_out        = dq_q;
    assign dq_strobe     = strobe_q;
    assign wait_o        = wait_q;
    assign wait_oe       = wait_oe_q;
    assign burst_active  = (state_q != PBTW_IDLE);
    assign burst_overrun = overrun_q;
endmodule
`default_nettype wire

// ==== verification/pbtw_core_assertions.sv ====
// Pin-level checks on the wait output, data strobe and burst state of the burst core
`timescale 1ns/100ps
`default_nettype none
module pbtw_core_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic wait_o,
    input wire logic wait_oe,
    input wire logic dq_strobe,
    input wire logic burst_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Pin driven low a few edges after select falls; sync delay is 3
    sequence s_busy;
        ##[1:5] (wait_oe && !wait_o);
    endsequence
    sequence s_off;
        ##[1:5] !wait_oe;
    endsequence
    wait_drive_a: assert property ($fell(chip_select_n) |-> s_busy)
        else $error("wait not driven low after select");
    first_low_a: assert property ($rose(wait_oe) |-> !wait_o)
        else $error("wait driven high too early");
    wait_release_a: assert property ($rose(chip_select_n) |-> s_off)
        else $error("wait not released");
    wait_stand_a: assert property (wait_oe && !chip_select_n |=> wait_oe)
        else $error("wait released while selected");
    ready_drive_a: assert property (wait_o |-> wait_oe && burst_active)
        else $error("wait high outside a burst");
    ready_hold_a: assert property (wait_o && !chip_select_n |=> wait_o)
        else $error("wait dropped in burst");
    no_restart_a: assert property (burst_active && !chip_select_n |=> burst_active)
        else $error("burst restarted");
    beat_ready_a: assert property (dq_strobe |-> burst_active && wait_o)
        else $error("beat before data phase");
endmodule
bind pbtw_core pbtw_core_checker u_chk (.mclk(mclk), .reset_n(reset_n),
    .chip_select_n(chip_select_n), .wait_o(wait_o), .wait_oe(wait_oe),
    .dq_strobe(dq_strobe), .burst_active(burst_active));
`default_nettype wire

// ==== verification/pbtw_host_model.sv ====
// Host controller model: select, address valid, burst clock
`timescale 1ns/100ps
`default_nettype none
module pbtw_host_model (
    input  wire logic mclk,
    output logic      chip_select_n,
    output logic      address_valid_n,
    output logic      burst_clk,
    output logic [3:0] latency,
    output int        rises
);
    initial begin
        chip_select_n = 1'b1;
        address_valid_n = 1'b1;
        burst_clk = 1'b0;
        latency = 4'h0;
        rises = 0;
    end
    // Clock stands low outside frames; half >= 3 keeps edges visible
    task automatic burst(input logic [3:0] lat, input int n, input int half);
        @(posedge mclk);
        rises <= 0;
        latency <= lat;
        chip_select_n <= 1'b0;
        address_valid_n <= 1'b0;
        repeat (half) @(posedge mclk);
        for (int i = 0; i < 2 * n; i++) begin
            burst_clk <= ~burst_clk;
            if (i == 3) address_valid_n <= 1'b1;
            if (!burst_clk) rises <= rises + 1;
            repeat (half) @(posedge mclk);
        end
        chip_select_n <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== verification/test_psram_burst_transition_wait.sv ====
// Bench for the burst core: latency, wait pin, prefetch data
`timescale 1ns/100ps
`default_nettype none
module test_psram_burst_transition_wait import pbtw_pkg::*; ;
    logic mclk = 1'b0, reset_n = 1'b0, array_valid = 1'b0, array_ready;
    logic cs_n, adv_n, bclk, dq_strobe, wait_o, wait_oe, b_act, b_ovr;
    logic [3:0] lat;
    logic [15:0] array_data = 16'h0, dq_out;
    logic [15:0] dq_q[$], lq[$];
    logic prev_wait = 1'b0;
    int rises, failures = 0, n_compared = 0;
    logic [3:0] lt[7] = '{4'h0, 4'h1, 4'h5, 4'hF, 4'h0, 4'h8, 4'h8};
    int hf[7] = '{3, 3, 4, 3, 3, 3, 10};
    int wd[7] = '{2, 1, 8, 8, 4, 0, 8};
    always #2.5 mclk = ~mclk;
    pbtw_host_model host (.mclk(mclk), .chip_select_n(cs_n), .address_valid_n(adv_n),
        .burst_clk(bclk), .latency(lat), .rises(rises));
    pbtw_core dut (.mclk(mclk), .reset_n(reset_n), .chip_select_n(cs_n),
        .address_valid_n(adv_n), .burst_clk(bclk), .latency(lat), .array_data(array_data),
        .array_valid(array_valid), .array_ready(array_ready), .dq_out(dq_out),
        .dq_strobe(dq_strobe), .wait_o(wait_o), .wait_oe(wait_oe),
        .burst_active(b_act), .burst_overrun(b_ovr));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Array side: hold each word until taken, note it for the monitor
    task automatic feed(input int w, input bit full);
        repeat (5) @(posedge mclk);
        for (int i = 0; i < w; i++) begin
            array_data <= 16'($urandom);
            array_valid <= 1'b1;
            do @(posedge mclk); while (array_ready !== 1'b1);
            dq_q.push_back(array_data);
        end
        array_valid <= 1'b0;
        #1;
        if (full) cmp(16'(array_ready), 16'h0);
    endtask
    // Short latencies clamp; abort leaves too few edges to reach ready
    task automatic run(input logic [3:0] l, input int half, input int w, input bit ab);
        logic [3:0] eff;
        int n;
        eff = (l < PBTW_LAT_MIN) ? PBTW_LAT_MIN : l;
        n = ab ? 2 : 32'(eff) + 10;
        if (!ab) lq.push_back(16'(eff) - 16'h1);
        fork
            host.burst(l, n, half);
            feed(w, half > 5);
        join
        cmp(16'({wait_oe, b_act}), 16'h0);
    endtask
    // Monitor: oldest note against each result as it shows
    always @(posedge mclk) begin
        if (dq_strobe === 1'b1)
            cmp(dq_out, dq_q.size() > 0 ? dq_q.pop_front() : 16'hXXXX);
        if (wait_o === 1'b1 && prev_wait === 1'b0)
            cmp(16'(rises), lq.size() > 0 ? lq.pop_front() : 16'hXXXX);
        prev_wait <= wait_o;
    end
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h4957));
        lt[4] = 4'($urandom_range(15, 0));
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int k = 0; k < 7; k++) run(lt[k], hf[k], wd[k], k == 5);
        // Host overstays the burst cycle on purpose; the overrun flag must show
        lq.push_back(16'(PBTW_LAT_MIN) - 16'h1);
        fork
            host.burst(PBTW_LAT_MIN, 26, 10);
            begin
                repeat (515) @(posedge mclk);
                cmp(16'(b_ovr), 16'h1);
            end
        join
        cmp(16'(b_ovr), 16'h0);
        cmp(16'(lq.size() + dq_q.size()), 16'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
